//--- core/cbm_pkg.sv
package cbm_pkg;
    // Register byte addresses on the local processor bus
    localparam logic [7:0] ADR_RD_PTR_LO = 8'h5A;
    localparam logic [7:0] ADR_RD_PTR_HI = 8'h5B;
    localparam logic [7:0] ADR_WR_PTR_LO = 8'h5C;
    localparam logic [7:0] ADR_WR_PTR_HI = 8'h5D;
    localparam logic [7:0] ADR_STOP_LO = 8'h5E;
    localparam logic [7:0] ADR_STOP_HI = 8'h5F;
    localparam logic [7:0] ADR_CLK_CFG = 8'h7F;
    // Field positions inside the clock config register
    localparam int CFG_DIV_LSB = 0;
    localparam int CFG_CYC_LSB = 6;
    // Values after reset
    localparam logic [15:0] RST_PTR = 16'h0000;
    localparam logic [15:0] RST_STOP = 16'h01FF;
    localparam logic [7:0] RST_CLK_CFG = 8'h00;
    // Smallest buffer is 256 bytes, size select 0..8 doubles it
    localparam logic [3:0] SIZE_SEL_MAX = 4'h8;
    localparam logic [15:0] SIZE_MASK_MIN = 16'h00FF;
    typedef enum {ST_IDLE, ST_ACCESS} cbm_state_t;
endpackage

//--- core/cbm_buffer_manager.sv
`timescale 1ns/10ps
module cbm_buffer_manager (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Local processor bus, multiplexed address and data
    input wire logic i_ale,
    input wire logic i_cs,
    input wire logic i_rd_b,
    input wire logic i_wr_b,
    input wire logic [7:0] i_ad,
    output logic [7:0] o_ad,
    output logic o_ad_oe,
    // Static configuration
    input wire logic [3:0] i_buf_size_sel,
    input wire logic i_oe_as_ce,
    input wire logic i_power_down,
    input wire logic i_host_upload,
    // Disk port
    input wire logic i_disk_req,
    input wire logic [7:0] i_disk_wdata,
    output logic [7:0] o_disk_rdata,
    output logic o_disk_done,
    // Host port
    input wire logic i_host_req,
    input wire logic i_host_pio,
    input wire logic [7:0] i_host_wdata,
    output logic [7:0] o_host_rdata,
    output logic o_host_done,
    output logic o_host_dma_req,
    // Buffer RAM
    output logic [15:0] o_ram_address_lines,
    output logic o_ram_output_enable_b,
    output logic o_ram_write_strobe_b,
    input wire logic [7:0] i_ram_data_bus,
    output logic [7:0] o_ram_data_bus,
    output logic o_ram_data_oe
);

    logic [15:0] read_address_pointer_r;
    logic [15:0] write_address_pointer_r;
    logic [15:0] host_stop_pointer_r;
    logic [7:0] clk_cfg_r;
    logic [7:0] bus_addr_r;
    logic wr_b_prev_r;
    logic wr_stb;
    logic disk_pend_r;
    logic [7:0] disk_data_r;
    logic host_pend_r;
    logic [7:0] host_data_r;
    logic stop_hit_r;
    cbm_pkg::cbm_state_t state_r;
    logic grant_disk_r;
    logic acc_write_r;
    logic [3:0] acc_cnt_r;
    logic [3:0] acc_last;
    logic [15:0] size_mask;
    logic start;
    logic start_disk;
    logic acc_end;
    logic use_wr_ptr;
    logic host_ptr_is_wr;
    logic [15:0] host_ptr;
    logic stop_wr_r;

    // Next pointer value, wrapping once it passes the buffer size
    function automatic logic [15:0] ptr_inc(input logic [15:0] p,
                                            input logic [15:0] mask);
        logic [16:0] sum;
        sum = {1'b0, p} + 17'h00001;
        if (sum > {1'b0, mask})
            ptr_inc = 16'h0000;
        else
            ptr_inc = sum[15:0];
    endfunction

    // Size mask; selections above the top clamp to 64K
    always_comb begin
        if (i_buf_size_sel >= cbm_pkg::SIZE_SEL_MAX)
            size_mask = 16'hFFFF;
        else
            size_mask = 16'(({16'h0000, cbm_pkg::SIZE_MASK_MIN} << 1
                              << i_buf_size_sel) >> 1 | 32'h000000FF);
    end

    // Access length in core cycles: cycle count times divider ratio
    always_comb begin
        logic [1:0] div;
        logic [1:0] cyc;
        div = clk_cfg_r[cbm_pkg::CFG_DIV_LSB +: 2];
        cyc = clk_cfg_r[cbm_pkg::CFG_CYC_LSB +: 2];
        acc_last = 4'(({2'b00, cyc} + 4'h1) * ({2'b00, div} + 4'h1)
                      - 4'h1);
    end

    // Upload: disk fills via write pointer, host drains via read pointer
    assign host_ptr_is_wr = ~i_host_upload;
    assign host_ptr = host_ptr_is_wr ? write_address_pointer_r
                                     : read_address_pointer_r;
    // Disk is granted ahead of a host request seen in the same cycle
    assign start = (state_r == cbm_pkg::ST_IDLE) && !i_power_down &&
                   (disk_pend_r || host_pend_r);
    assign start_disk = disk_pend_r;
    assign use_wr_ptr = start_disk ? i_host_upload : host_ptr_is_wr;
    assign acc_end = (state_r == cbm_pkg::ST_ACCESS) &&
                     (acc_cnt_r == acc_last);
    assign wr_stb = wr_b_prev_r && !i_wr_b && i_cs;

    // Address latch and write strobe edge tracking
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bus_addr_r <= 8'h00;
            wr_b_prev_r <= 1'b1;
        end else begin
            if (i_ale)
                bus_addr_r <= i_ad;
            wr_b_prev_r <= i_wr_b;
        end
    end

    // Register read port, driven while chip select and read strobe hold
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ad <= 8'h00;
            o_ad_oe <= 1'b0;
        end else begin
            o_ad_oe <= i_cs && !i_rd_b;
            case (bus_addr_r)
                cbm_pkg::ADR_RD_PTR_LO: o_ad <= read_address_pointer_r[7:0];
                cbm_pkg::ADR_RD_PTR_HI: o_ad <= read_address_pointer_r[15:8];
                cbm_pkg::ADR_WR_PTR_LO: o_ad <= write_address_pointer_r[7:0];
                cbm_pkg::ADR_WR_PTR_HI: o_ad <= write_address_pointer_r[15:8];
                cbm_pkg::ADR_STOP_LO: o_ad <= host_stop_pointer_r[7:0];
                cbm_pkg::ADR_STOP_HI: o_ad <= host_stop_pointer_r[15:8];
                cbm_pkg::ADR_CLK_CFG: o_ad <= clk_cfg_r;
                default: o_ad <= 8'h00;
            endcase
        end
    end

    // Configuration registers
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            clk_cfg_r <= cbm_pkg::RST_CLK_CFG;
            host_stop_pointer_r <= cbm_pkg::RST_STOP;
        end else if (wr_stb) begin
            case (bus_addr_r)
                cbm_pkg::ADR_CLK_CFG: clk_cfg_r <= i_ad;
                cbm_pkg::ADR_STOP_LO: host_stop_pointer_r[7:0] <= i_ad;
                cbm_pkg::ADR_STOP_HI: host_stop_pointer_r[15:8] <= i_ad;
                default: clk_cfg_r <= clk_cfg_r;
            endcase
        end
    end

    // Pointers; a processor write overrides the written byte of a same-cycle hardware step
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            read_address_pointer_r <= cbm_pkg::RST_PTR;
            write_address_pointer_r <= cbm_pkg::RST_PTR;
        end else begin
            if (acc_end && acc_write_r)
                write_address_pointer_r <= ptr_inc(write_address_pointer_r,
                                                   size_mask);
            if (acc_end && !acc_write_r)
                read_address_pointer_r <= ptr_inc(read_address_pointer_r,
                                                  size_mask);
            if (wr_stb && bus_addr_r == cbm_pkg::ADR_RD_PTR_LO)
                read_address_pointer_r[7:0] <= i_ad;
            if (wr_stb && bus_addr_r == cbm_pkg::ADR_RD_PTR_HI)
                read_address_pointer_r[15:8] <= i_ad;
            if (wr_stb && bus_addr_r == cbm_pkg::ADR_WR_PTR_LO)
                write_address_pointer_r[7:0] <= i_ad;
            if (wr_stb && bus_addr_r == cbm_pkg::ADR_WR_PTR_HI)
                write_address_pointer_r[15:8] <= i_ad;
        end
    end

    // One-byte holding stages per port; a new request sets over the grant
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            disk_pend_r <= 1'b0;
            disk_data_r <= 8'h00;
            host_pend_r <= 1'b0;
            host_data_r <= 8'h00;
        end else begin
            if (start && start_disk)
                disk_pend_r <= 1'b0;
            if (i_disk_req) begin
                disk_pend_r <= 1'b1;
                disk_data_r <= i_disk_wdata;
            end
            if (start && !start_disk)
                host_pend_r <= 1'b0;
            // DMA requests are dropped while suspended, PIO always passes
            if (i_host_req && (i_host_pio || !stop_hit_r)) begin
                host_pend_r <= 1'b1;
                host_data_r <= i_host_wdata;
            end
        end
    end

    // Access sequencer
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= cbm_pkg::ST_IDLE;
            acc_cnt_r <= 4'h0;
            grant_disk_r <= 1'b0;
            acc_write_r <= 1'b0;
        end else begin
            case (state_r)
                cbm_pkg::ST_IDLE: begin
                    acc_cnt_r <= 4'h0;
                    if (start) begin
                        state_r <= cbm_pkg::ST_ACCESS;
                        grant_disk_r <= start_disk;
                        acc_write_r <= use_wr_ptr;
                    end
                end
                cbm_pkg::ST_ACCESS: begin
                    acc_cnt_r <= acc_cnt_r + 4'h1;
                    if (acc_end)
                        state_r <= cbm_pkg::ST_IDLE;
                end
                default: state_r <= cbm_pkg::ST_IDLE;
            endcase
        end
    end

    // RAM pins, all registered on the core clock
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ram_address_lines <= 16'h0000;
            o_ram_output_enable_b <= 1'b1;
            o_ram_write_strobe_b <= 1'b1;
            o_ram_data_bus <= 8'h00;
            o_ram_data_oe <= 1'b0;
        end else if (start) begin
            o_ram_address_lines <= use_wr_ptr ? write_address_pointer_r
                                              : read_address_pointer_r;
            // Chip-enable mode keeps the pin low for writes as well
            o_ram_output_enable_b <= use_wr_ptr && !i_oe_as_ce;
            o_ram_write_strobe_b <= !use_wr_ptr;
            o_ram_data_bus <= start_disk ? disk_data_r : host_data_r;
            o_ram_data_oe <= use_wr_ptr;
        // Compare one bit wider so the longest access still releases
        end else if (state_r == cbm_pkg::ST_ACCESS &&
                     {1'b0, acc_cnt_r} + 5'h01 >= {1'b0, acc_last}) begin
            // Strobe rises one cycle early in accesses longer than one cycle, so data holds past its edge
            o_ram_write_strobe_b <= 1'b1;
            if (acc_end) begin
                o_ram_output_enable_b <= 1'b1;
                o_ram_data_oe <= 1'b0;
            end
        end
    end

    // Read data capture at the access end, the last rising core clock edge of the access
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_disk_rdata <= 8'h00;
            o_host_rdata <= 8'h00;
            o_disk_done <= 1'b0;
            o_host_done <= 1'b0;
        end else begin
            o_disk_done <= acc_end && grant_disk_r;
            o_host_done <= acc_end && !grant_disk_r;
            if (acc_end && !acc_write_r && grant_disk_r)
                o_disk_rdata <= i_ram_data_bus;
            if (acc_end && !acc_write_r && !grant_disk_r)
                o_host_rdata <= i_ram_data_bus;
        end
    end

    // Stop pointer suspension of host DMA
    // A rewrite is judged one cycle later against the new stop value;
    // at the write edge itself the old, still equal value would be seen
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stop_wr_r <= 1'b0;
            stop_hit_r <= 1'b0;
            o_host_dma_req <= 1'b0;
        end else begin
            stop_wr_r <= wr_stb && (bus_addr_r == cbm_pkg::ADR_STOP_LO ||
                                    bus_addr_r == cbm_pkg::ADR_STOP_HI);
            if (host_ptr == host_stop_pointer_r)
                stop_hit_r <= 1'b1;
            else if (stop_wr_r)
                stop_hit_r <= 1'b0;
            o_host_dma_req <= !stop_hit_r && !i_power_down &&
                              host_ptr != host_stop_pointer_r &&
                              !host_pend_r;
        end
    end

endmodule

//--- bench/cbm_sram_model.sv
`timescale 1ns/10ps
module cbm_sram_model (
    // Clock used to place stores mid-cycle and to record the last read byte
    input wire logic i_clk,
    // Static RAM pins
    input wire logic [15:0] i_addr,
    input wire logic i_oe_b,
    input wire logic i_we_b,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_r = 8'h00;
    // Store mid-cycle so the strobe release never races the address
    always @(negedge i_clk) begin
        if (!i_we_b) begin
            mem[i_addr] <= i_data;
        end
    end
    // Remember the last driven byte
    always @(posedge i_clk) begin
        if (!i_oe_b) begin
            last_r <= mem[i_addr];
        end
    end
    // A released bus shows the inverse, never a held value
    always_comb begin
        o_data = i_oe_b ? ~last_r : mem[i_addr];
    end
endmodule

//--- bench/cbm_asserts.sv
`timescale 1ns/10ps
module cbm_asserts (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Watched inputs
    input wire logic i_power_down,
    input wire logic i_oe_as_ce,
    input wire logic i_disk_req,
    // Watched outputs
    input wire logic o_disk_done,
    input wire logic o_host_done,
    input wire logic o_host_dma_req,
    input wire logic [15:0] o_ram_address_lines,
    input wire logic o_ram_output_enable_b,
    input wire logic o_ram_write_strobe_b,
    input wire logic o_ram_data_oe
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    a_we_data: assert property (
        !o_ram_write_strobe_b |-> o_ram_data_oe)
        else $error("write strobe low without data drive");
    a_read_no_we: assert property (
        !o_ram_output_enable_b && !i_oe_as_ce |-> o_ram_write_strobe_b)
        else $error("write strobe during read");
    a_ce_write: assert property (
        i_oe_as_ce && !o_ram_write_strobe_b |-> !o_ram_output_enable_b)
        else $error("chip enable high during write");
    a_addr_hold: assert property (
        !o_ram_write_strobe_b |=> o_ram_write_strobe_b
        || $stable(o_ram_address_lines))
        else $error("address moved under write strobe");
    a_disk_pulse: assert property (
        o_disk_done |=> !o_disk_done)
        else $error("disk done longer than one cycle");
    a_host_pulse: assert property (
        o_host_done |=> !o_host_done)
        else $error("host done longer than one cycle");
    a_pd_start: assert property (
        $fell(o_ram_write_strobe_b) |-> !$past(i_power_down))
        else $error("access started in power down");
    a_pd_dma: assert property (
        i_power_down |=> !o_host_dma_req)
        else $error("dma request in power down");
    a_disk_served: assert property (
        i_disk_req && !i_power_down |-> ##[2:40] o_disk_done)
        else $error("disk request not served");
    c_disk: cover property (o_disk_done);
    c_host: cover property (o_host_done);
    c_stop: cover property ($fell(o_host_dma_req));
endmodule
bind cbm_buffer_manager cbm_asserts u_chk (.i_core_clk, .i_rst_b,
    .i_power_down, .i_oe_as_ce, .i_disk_req, .o_disk_done, .o_host_done,
    .o_host_dma_req, .o_ram_address_lines, .o_ram_output_enable_b,
    .o_ram_write_strobe_b, .o_ram_data_oe);

//--- bench/tb_cbm_buffer_manager.sv
`timescale 1ns/10ps
module tb_cbm_buffer_manager;
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_ale = 1'b0, i_cs = 1'b0, i_rd_b = 1'b1, i_wr_b = 1'b1;
    logic [7:0] i_ad = 8'h00, i_disk_wdata = 8'h00, i_host_wdata = 8'h00;
    logic [3:0] i_buf_size_sel = 4'h0;
    logic i_oe_as_ce = 1'b0, i_power_down = 1'b0, i_host_upload = 1'b1;
    logic i_disk_req = 1'b0, i_host_req = 1'b0, i_host_pio = 1'b1;
    logic [7:0] o_ad, o_disk_rdata, o_host_rdata, o_ram_data_bus, ram_q, bus;
    logic o_ad_oe, o_disk_done, o_host_done, o_host_dma_req, o_ram_data_oe;
    logic [15:0] o_ram_address_lines;
    logic o_ram_output_enable_b, o_ram_write_strobe_b;
    int failures = 0, tests_run = 0, n, td, th;
    logic [7:0] q;
    logic qoe;
    // Whoever drives the data bus wins it
    assign bus = o_ram_data_oe ? o_ram_data_bus : ram_q;
    // Clock of 4 ns period
    always #2 i_core_clk = ~i_core_clk;
    cbm_buffer_manager dut (.i_core_clk, .i_rst_b, .i_ale, .i_cs, .i_rd_b,
        .i_wr_b, .i_ad, .o_ad, .o_ad_oe, .i_buf_size_sel, .i_oe_as_ce,
        .i_power_down, .i_host_upload, .i_disk_req, .i_disk_wdata,
        .o_disk_rdata, .o_disk_done, .i_host_req, .i_host_pio, .i_host_wdata,
        .o_host_rdata, .o_host_done, .o_host_dma_req, .o_ram_address_lines,
        .o_ram_output_enable_b, .o_ram_write_strobe_b, .i_ram_data_bus(bus),
        .o_ram_data_bus, .o_ram_data_oe);
    cbm_sram_model ram (.i_clk(i_core_clk), .i_addr(o_ram_address_lines),
        .i_oe_b(o_ram_output_enable_b), .i_we_b(o_ram_write_strobe_b),
        .i_data(bus), .o_data(ram_q));
    task end_of_test;
        if (failures == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
            failures++;
        end
    endtask
    // Whole bus cycle, address phase then data phase, shared by reads and writes
    task cyc(input logic [7:0] a, input logic wr, input logic [7:0] d);
        @(negedge i_core_clk);
        i_ale = 1'b1;
        i_ad = a;
        @(negedge i_core_clk);
        i_ale = 1'b0;
        i_cs = 1'b1;
        i_ad = d;
        i_wr_b = !wr;
        i_rd_b = wr;
        repeat (2) @(negedge i_core_clk);
        q = o_ad;
        qoe = o_ad_oe;
        i_cs = 1'b0;
        i_wr_b = 1'b1;
        i_rd_b = 1'b1;
    endtask
    task rd16(input logic [7:0] a, input logic [15:0] exp);
        logic [7:0] lo;
        cyc(a, 1'b0, 8'h00);
        lo = q;
        cyc(a + 8'h01, 1'b0, 8'h00);
        chk({q, lo}, exp);
    endtask
    task wr16(input logic [7:0] a, input logic [15:0] d);
        cyc(a, 1'b1, d[7:0]);
        cyc(a + 8'h01, 1'b1, d[15:8]);
    endtask
    // One access request; a run out of time ends the test when required
    task acc(input logic disk, input logic [7:0] d, input logic must);
        @(negedge i_core_clk);
        i_disk_req = disk;
        i_host_req = !disk;
        i_disk_wdata = d;
        i_host_wdata = d;
        n = 0;
        for (int k = 1; k < 60 && n == 0; k++) begin
            @(negedge i_core_clk);
            i_disk_req = 1'b0;
            i_host_req = 1'b0;
            if ((disk ? o_disk_done : o_host_done) === 1'b1) begin
                n = k;
            end
        end
        if (must && n == 0) begin
            failures++;
            end_of_test;
        end
    endtask
    // Main sequence
    initial begin
        repeat (3) @(negedge i_core_clk);
        i_rst_b = 1'b1;
        rd16(cbm_pkg::ADR_RD_PTR_LO, cbm_pkg::RST_PTR);
        rd16(cbm_pkg::ADR_STOP_LO, cbm_pkg::RST_STOP);
        cyc(cbm_pkg::ADR_CLK_CFG, 1'b0, 8'h00);
        chk(q, cbm_pkg::RST_CLK_CFG);
        chk(16'(qoe), 16'h0001);
        cyc(8'h40, 1'b0, 8'h00);
        chk(q, 16'h0000);
        wr16(cbm_pkg::ADR_WR_PTR_LO, 16'h00FE);
        chk(16'(qoe), 16'h0000);
        acc(1'b1, 8'hA5, 1'b1);
        chk(n[15:0], 16'h0003);
        acc(1'b1, 8'h3C, 1'b1);
        rd16(cbm_pkg::ADR_WR_PTR_LO, 16'h0000);
        chk(ram.mem[16'h00FF], 16'h003C);
        wr16(cbm_pkg::ADR_RD_PTR_LO, 16'h00FE);
        acc(1'b0, 8'h00, 1'b1);
        chk(o_host_rdata, 16'h00A5);
        acc(1'b0, 8'h00, 1'b1);
        chk(o_host_rdata, 16'h003C);
        rd16(cbm_pkg::ADR_RD_PTR_LO, 16'h0000);
        i_buf_size_sel = 4'h1;
        wr16(cbm_pkg::ADR_WR_PTR_LO, 16'h00FF);
        acc(1'b1, 8'h01, 1'b1);
        rd16(cbm_pkg::ADR_WR_PTR_LO, 16'h0100);
        i_buf_size_sel = 4'h8;
        wr16(cbm_pkg::ADR_WR_PTR_LO, 16'hFFFF);
        acc(1'b1, 8'h02, 1'b1);
        rd16(cbm_pkg::ADR_WR_PTR_LO, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            cyc(cbm_pkg::ADR_CLK_CFG, 1'b1, {i[1:0], 4'h0, i[1:0]});
            acc(1'b1, 8'h00, 1'b1);
            chk(n[15:0], 16'(2 + (i + 1) * (i + 1)));
        end
        cyc(cbm_pkg::ADR_CLK_CFG, 1'b1, 8'h00);
        // Chip-enable option must still let the write land
        i_oe_as_ce = 1'b1;
        acc(1'b1, 8'h77, 1'b1);
        i_oe_as_ce = 1'b0;
        chk(ram.mem[16'h0004], 16'h0077);
        // Both ports ask in the same cycle
        @(negedge i_core_clk);
        i_disk_req = 1'b1;
        i_host_req = 1'b1;
        td = 0;
        th = 0;
        for (int k = 1; k < 60 && th == 0; k++) begin
            @(negedge i_core_clk);
            i_disk_req = 1'b0;
            i_host_req = 1'b0;
            td = (o_disk_done === 1'b1) ? k : td;
            th = (o_host_done === 1'b1) ? k : th;
        end
        chk(16'(td != 0 && td < th), 16'h0001);
        wr16(cbm_pkg::ADR_RD_PTR_LO, 16'h0010);
        wr16(cbm_pkg::ADR_STOP_LO, 16'h0012);
        repeat (2) @(negedge i_core_clk);
        chk(o_host_dma_req, 16'h0001);
        i_host_pio = 1'b0;
        acc(1'b0, 8'h00, 1'b1);
        acc(1'b0, 8'h00, 1'b1);
        repeat (2) @(negedge i_core_clk);
        chk(o_host_dma_req, 16'h0000);
        acc(1'b0, 8'h00, 1'b0);
        chk(n[15:0], 16'h0000);
        cyc(cbm_pkg::ADR_STOP_LO, 1'b1, 8'h20);
        repeat (2) @(negedge i_core_clk);
        chk(o_host_dma_req, 16'h0001);
        i_host_pio = 1'b1;
        // A disk request in power down waits until power returns
        i_power_down = 1'b1;
        acc(1'b1, 8'h00, 1'b0);
        chk(n[15:0], 16'h0000);
        chk(o_host_dma_req, 16'h0000);
        i_power_down = 1'b0;
        repeat (4) @(negedge i_core_clk);
        // Download: host fills through the write pointer, disk drains
        i_host_upload = 1'b0;
        wr16(cbm_pkg::ADR_WR_PTR_LO, 16'h0040);
        wr16(cbm_pkg::ADR_RD_PTR_LO, 16'h0040);
        acc(1'b0, 8'h5A, 1'b1);
        acc(1'b1, 8'h00, 1'b1);
        chk(o_disk_rdata, 16'h005A);
        i_rst_b = 1'b0;
        @(negedge i_core_clk);
        i_rst_b = 1'b1;
        rd16(cbm_pkg::ADR_WR_PTR_LO, cbm_pkg::RST_PTR);
        end_of_test;
    end
endmodule
